// ### verilog/ppp_ports.sv
// programmable peripheral ports: three 8-bit ports behind an APB slave
//
// Implementation choice: register access over APB.
`timescale 1ns/1ns
module ppp_ports (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pclk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  first_port_pins_in,
  output logic      [7:0]  first_port_pins_out,
  output logic      [7:0]  first_port_pins_oe,
  input  wire logic [7:0]  second_port_pins_in,
  output logic      [7:0]  second_port_pins_out,
  output logic      [7:0]  second_port_pins_oe,
  input  wire logic [7:0]  third_port_pins_in,
  output logic      [7:0]  third_port_pins_out,
  output logic      [7:0]  third_port_pins_oe
);

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  function automatic ppp_pkg::ppp_mode_e group_a_mode(input logic [7:0] ctl);
    if (ctl[ppp_pkg::PPP_CTL_A_MODE_HIGH]) begin
      return ppp_pkg::PPP_MODE_BIDIR;
    end else if (ctl[ppp_pkg::PPP_CTL_A_MODE_LOW]) begin
      return ppp_pkg::PPP_MODE_STROBED;
    end
    return ppp_pkg::PPP_MODE_BASIC;
  endfunction : group_a_mode

  function automatic ppp_pkg::ppp_mode_e group_b_mode(input logic [7:0] ctl);
    if (ctl[ppp_pkg::PPP_CTL_B_MODE]) begin
      return ppp_pkg::PPP_MODE_STROBED;
    end
    return ppp_pkg::PPP_MODE_BASIC;
  endfunction : group_b_mode

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  ppp_pkg::ppp_pins_s pins_sync;

  ppp_sync2 #(
    .WIDTH (24)
  ) u_pin_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .pclk_en  (pclk_en),
    .async_in ({first_port_pins_in, second_port_pins_in, third_port_pins_in}),
    .sync_out (pins_sync)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ppp_pkg::ppp_state_s state_reg;
  ppp_pkg::ppp_state_s state_next;

  ppp_pkg::ppp_mode_e  mode_a;
  ppp_pkg::ppp_mode_e  mode_b;
  ppp_pkg::ppp_mode_e  new_mode_a;
  ppp_pkg::ppp_mode_e  new_mode_b;
  logic                setup_phase;
  logic                access_wr;
  logic                access_rd;
  logic                strobe_a;
  logic                strobe_b;
  logic                ack_a;
  logic                ack_b;
  logic                strobe_a_fall;
  logic                strobe_b_fall;
  logic                ack_a_fall;
  logic                ack_b_fall;
  logic                a_is_input;
  logic                b_is_input;
  logic                req_a;
  logic                req_b;
  logic [2:0]          bit_index;
  logic [7:0]          c_read;
  logic [7:0]          rd_value;
  logic                addr_hit;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_next  = state_reg;
    mode_a      = group_a_mode(state_reg.ctl);
    mode_b      = group_b_mode(state_reg.ctl);
    a_is_input  = state_reg.ctl[ppp_pkg::PPP_CTL_A_DIR];
    b_is_input  = state_reg.ctl[ppp_pkg::PPP_CTL_B_DIR];
    setup_phase = psel && !penable;
    access_wr   = psel && penable && state_reg.pready && pwrite;
    access_rd   = psel && penable && state_reg.pready && !pwrite;
    bit_index   = pwdata[ppp_pkg::PPP_CTL_INDEX_MSB:ppp_pkg::PPP_CTL_INDEX_LSB];

    // handshake inputs after synchronisation, edges against last cycle
    strobe_a      = pins_sync.c[ppp_pkg::PPP_PC_A_STROBE];
    ack_a         = pins_sync.c[ppp_pkg::PPP_PC_A_ACK];
    strobe_b      = pins_sync.c[ppp_pkg::PPP_PC_B_STROBE];
    ack_b         = pins_sync.c[ppp_pkg::PPP_PC_B_STROBE];
    strobe_a_fall = state_reg.prev_c[ppp_pkg::PPP_PC_A_STROBE] && !strobe_a;
    ack_a_fall    = state_reg.prev_c[ppp_pkg::PPP_PC_A_ACK] && !ack_a;
    strobe_b_fall = state_reg.prev_c[ppp_pkg::PPP_PC_B_STROBE] && !strobe_b;
    ack_b_fall    = strobe_b_fall;
    state_next.prev_c = pins_sync.c;

    // ----------------------------------------------------------------
    // APB answer: data prepared in setup, pready high in access
    // ----------------------------------------------------------------
    c_read   = (state_reg.pin_oe.c & state_reg.pin_out.c) | (~state_reg.pin_oe.c & pins_sync.c);
    addr_hit = 1'b1;
    rd_value = 8'h00;
    case (paddr)
      ppp_pkg::PPP_OFS_PORT_A_DATA: begin
        if (mode_a == ppp_pkg::PPP_MODE_BIDIR) begin
          rd_value = state_reg.a_in_lat;
        end else if (!a_is_input) begin
          rd_value = state_reg.a_lat;
        end else if (mode_a == ppp_pkg::PPP_MODE_STROBED) begin
          rd_value = state_reg.a_in_lat;
        end else begin
          rd_value = pins_sync.a;
        end
      end
      ppp_pkg::PPP_OFS_PORT_B_DATA: begin
        if (!b_is_input) begin
          rd_value = state_reg.b_lat;
        end else if (mode_b == ppp_pkg::PPP_MODE_STROBED) begin
          rd_value = state_reg.b_in_lat;
        end else begin
          rd_value = pins_sync.b;
        end
      end
      ppp_pkg::PPP_OFS_PORT_C_DATA: begin
        rd_value = c_read;
      end
      ppp_pkg::PPP_OFS_MODE_CONTROL: begin
        rd_value = 8'h00;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase

    state_next.pready  = 1'b0;
    state_next.pslverr = 1'b0;
    if (setup_phase) begin
      state_next.pready  = 1'b1;
      state_next.pslverr = !addr_hit;
      state_next.prdata  = {24'h000000, rd_value};
    end

    // ----------------------------------------------------------------
    // strobed inputs: latch while strobe low, flag on falling edge
    // ----------------------------------------------------------------
    if ((mode_a == ppp_pkg::PPP_MODE_BIDIR) || (mode_a == ppp_pkg::PPP_MODE_STROBED && a_is_input)) begin
      if (!strobe_a) begin
        state_next.a_in_lat = pins_sync.a;
      end
      if (access_rd && paddr == ppp_pkg::PPP_OFS_PORT_A_DATA) begin
        state_next.ibf_a = 1'b0;
      end
      if (strobe_a_fall) begin
        state_next.ibf_a = 1'b1;
      end
    end
    if (mode_b == ppp_pkg::PPP_MODE_STROBED && b_is_input) begin
      if (!strobe_b) begin
        state_next.b_in_lat = pins_sync.b;
      end
      if (access_rd && paddr == ppp_pkg::PPP_OFS_PORT_B_DATA) begin
        state_next.ibf_b = 1'b0;
      end
      if (strobe_b_fall) begin
        state_next.ibf_b = 1'b1;
      end
    end

    // strobed outputs: acknowledge empties the latch, a write fills it
    if ((mode_a == ppp_pkg::PPP_MODE_BIDIR) || (mode_a == ppp_pkg::PPP_MODE_STROBED && !a_is_input)) begin
      if (ack_a_fall) begin
        state_next.obf_a = 1'b0;
      end
      if (access_wr && paddr == ppp_pkg::PPP_OFS_PORT_A_DATA) begin
        state_next.obf_a = 1'b1;
      end
    end
    if (mode_b == ppp_pkg::PPP_MODE_STROBED && !b_is_input) begin
      if (ack_b_fall) begin
        state_next.obf_b = 1'b0;
      end
      if (access_wr && paddr == ppp_pkg::PPP_OFS_PORT_B_DATA) begin
        state_next.obf_b = 1'b1;
      end
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    if (access_wr) begin
      case (paddr)
        ppp_pkg::PPP_OFS_PORT_A_DATA: begin
          state_next.a_lat = pwdata[7:0];
        end
        ppp_pkg::PPP_OFS_PORT_B_DATA: begin
          state_next.b_lat = pwdata[7:0];
        end
        ppp_pkg::PPP_OFS_PORT_C_DATA: begin
          state_next.c_lat = pwdata[7:0];
        end
        ppp_pkg::PPP_OFS_MODE_CONTROL: begin
          if (pwdata[ppp_pkg::PPP_CTL_SELECT]) begin
            state_next.ctl      = pwdata[7:0];
            state_next.a_lat    = 8'h00;
            state_next.b_lat    = 8'h00;
            state_next.c_lat    = 8'h00;
            state_next.a_in_lat = 8'h00;
            state_next.b_in_lat = 8'h00;
            state_next.ibf_a    = 1'b0;
            state_next.ibf_b    = 1'b0;
            state_next.obf_a    = 1'b0;
            state_next.obf_b    = 1'b0;
            state_next.irq_enable_flop_a   = 1'b0;
            state_next.irq_enable_flop_b   = 1'b0;
          end else begin
            state_next.c_lat[bit_index] = pwdata[ppp_pkg::PPP_CTL_SET_VALUE];
            if (mode_a != ppp_pkg::PPP_MODE_BASIC &&
                (bit_index == 3'(ppp_pkg::PPP_PC_A_STROBE) || bit_index == 3'(ppp_pkg::PPP_PC_A_ACK))) begin
              state_next.irq_enable_flop_a = pwdata[ppp_pkg::PPP_CTL_SET_VALUE];
            end
            if (mode_b != ppp_pkg::PPP_MODE_BASIC && bit_index == 3'(ppp_pkg::PPP_PC_B_STROBE)) begin
              state_next.irq_enable_flop_b = pwdata[ppp_pkg::PPP_CTL_SET_VALUE];
            end
          end
        end
        default: begin
        end
      endcase
    end

    // ----------------------------------------------------------------
    // pin image from the new state
    // ----------------------------------------------------------------
    new_mode_a = group_a_mode(state_next.ctl);
    new_mode_b = group_b_mode(state_next.ctl);

    // service requests: input side and output side, gated by enable
    req_a = 1'b0;
    if (new_mode_a != ppp_pkg::PPP_MODE_BASIC) begin
      if (new_mode_a == ppp_pkg::PPP_MODE_BIDIR || state_next.ctl[ppp_pkg::PPP_CTL_A_DIR]) begin
        req_a = req_a || (strobe_a && state_next.ibf_a && state_next.irq_enable_flop_a);
      end
      if (new_mode_a == ppp_pkg::PPP_MODE_BIDIR || !state_next.ctl[ppp_pkg::PPP_CTL_A_DIR]) begin
        req_a = req_a || (ack_a && !state_next.obf_a && state_next.irq_enable_flop_a);
      end
    end
    req_b = 1'b0;
    if (new_mode_b == ppp_pkg::PPP_MODE_STROBED) begin
      if (state_next.ctl[ppp_pkg::PPP_CTL_B_DIR]) begin
        req_b = strobe_b && state_next.ibf_b && state_next.irq_enable_flop_b;
      end else begin
        req_b = ack_b && !state_next.obf_b && state_next.irq_enable_flop_b;
      end
    end

    // data ports: latched value, enable from direction, or from ack for port A in bidir mode
    state_next.pin_out.a = state_next.a_lat;
    state_next.pin_out.b = state_next.b_lat;
    state_next.pin_oe.b  = {8{!state_next.ctl[ppp_pkg::PPP_CTL_B_DIR]}};
    if (new_mode_a == ppp_pkg::PPP_MODE_BIDIR) begin
      state_next.pin_oe.a = {8{!ack_a}};
    end else begin
      state_next.pin_oe.a = {8{!state_next.ctl[ppp_pkg::PPP_CTL_A_DIR]}};
    end

    // port C halves as plain I/O first
    state_next.pin_out.c     = state_next.c_lat;
    state_next.pin_oe.c[7:4] = {4{!state_next.ctl[ppp_pkg::PPP_CTL_C_UPPER_DIR]}};
    state_next.pin_oe.c[3:0] = {4{!state_next.ctl[ppp_pkg::PPP_CTL_C_LOWER_DIR]}};

    // group A handshake lines take over C bit 3, plus 5:4 on input and 7:6 on output (all of 7:3 in bidir)
    if (new_mode_a != ppp_pkg::PPP_MODE_BASIC) begin
      state_next.pin_out.c[ppp_pkg::PPP_PC_A_REQUEST] = req_a;
      state_next.pin_oe.c[ppp_pkg::PPP_PC_A_REQUEST]  = 1'b1;
      if (new_mode_a == ppp_pkg::PPP_MODE_BIDIR || state_next.ctl[ppp_pkg::PPP_CTL_A_DIR]) begin
        state_next.pin_oe.c[ppp_pkg::PPP_PC_A_STROBE] = 1'b0;
        state_next.pin_out.c[ppp_pkg::PPP_PC_A_FULL]  = state_next.ibf_a;
        state_next.pin_oe.c[ppp_pkg::PPP_PC_A_FULL]   = 1'b1;
      end
      if (new_mode_a == ppp_pkg::PPP_MODE_BIDIR || !state_next.ctl[ppp_pkg::PPP_CTL_A_DIR]) begin
        state_next.pin_oe.c[ppp_pkg::PPP_PC_A_ACK]      = 1'b0;
        state_next.pin_out.c[ppp_pkg::PPP_PC_A_EMPTY_N] = !state_next.obf_a;
        state_next.pin_oe.c[ppp_pkg::PPP_PC_A_EMPTY_N]  = 1'b1;
      end
    end

    // group B handshake lines take over C bits 2:0
    if (new_mode_b == ppp_pkg::PPP_MODE_STROBED) begin
      state_next.pin_out.c[ppp_pkg::PPP_PC_B_REQUEST] = req_b;
      state_next.pin_oe.c[ppp_pkg::PPP_PC_B_REQUEST]  = 1'b1;
      state_next.pin_oe.c[ppp_pkg::PPP_PC_B_STROBE]   = 1'b0;
      state_next.pin_oe.c[ppp_pkg::PPP_PC_B_FLAG]     = 1'b1;
      if (state_next.ctl[ppp_pkg::PPP_CTL_B_DIR]) begin
        state_next.pin_out.c[ppp_pkg::PPP_PC_B_FLAG] = state_next.ibf_b;
      end else begin
        state_next.pin_out.c[ppp_pkg::PPP_PC_B_FLAG] = !state_next.obf_b;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ppp_pkg::PPP_STATE_RESET;
    end else if (pclk_en) begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata               = state_reg.prdata;
  assign pready               = state_reg.pready;
  assign pslverr              = state_reg.pslverr;
  assign first_port_pins_out  = state_reg.pin_out.a;
  assign first_port_pins_oe   = state_reg.pin_oe.a;
  assign second_port_pins_out = state_reg.pin_out.b;
  assign second_port_pins_oe  = state_reg.pin_oe.b;
  assign third_port_pins_out  = state_reg.pin_out.c;
  assign third_port_pins_oe   = state_reg.pin_oe.c;

endmodule : ppp_ports

// ### verilog/ppp_pkg.sv
// package: offsets, field layout, reset values and carriers of the peripheral ports
package ppp_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] PPP_OFS_PORT_A_DATA  = 8'h00;
  localparam logic [7:0] PPP_OFS_PORT_B_DATA  = 8'h04;
  localparam logic [7:0] PPP_OFS_PORT_C_DATA  = 8'h08;
  localparam logic [7:0] PPP_OFS_MODE_CONTROL = 8'h0C;

  // ----------------------------------------------------------------
  // mode control word layout
  // ----------------------------------------------------------------
  localparam logic [7:0] PPP_CTL_RESET        = 8'h1B;
  localparam int         PPP_CTL_SELECT       = 7;
  localparam int         PPP_CTL_A_MODE_HIGH  = 6;
  localparam int         PPP_CTL_A_MODE_LOW   = 5;
  localparam int         PPP_CTL_A_DIR        = 4;
  localparam int         PPP_CTL_C_UPPER_DIR  = 3;
  localparam int         PPP_CTL_B_MODE       = 2;
  localparam int         PPP_CTL_B_DIR        = 1;
  localparam int         PPP_CTL_C_LOWER_DIR  = 0;
  localparam int         PPP_CTL_INDEX_MSB    = 3;
  localparam int         PPP_CTL_INDEX_LSB    = 1;
  localparam int         PPP_CTL_SET_VALUE    = 0;

  // ----------------------------------------------------------------
  // port C handshake pin positions
  // ----------------------------------------------------------------
  localparam int         PPP_PC_B_REQUEST     = 0;
  localparam int         PPP_PC_B_FLAG        = 1;
  localparam int         PPP_PC_B_STROBE      = 2;
  localparam int         PPP_PC_A_REQUEST     = 3;
  localparam int         PPP_PC_A_STROBE      = 4;
  localparam int         PPP_PC_A_FULL        = 5;
  localparam int         PPP_PC_A_ACK         = 6;
  localparam int         PPP_PC_A_EMPTY_N     = 7;

  // ----------------------------------------------------------------
  // group modes
  // ----------------------------------------------------------------
  typedef enum {
    PPP_MODE_BASIC,
    PPP_MODE_STROBED,
    PPP_MODE_BIDIR
  } ppp_mode_e;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
  } ppp_pins_s;

  typedef struct packed {
    logic [7:0]  ctl;
    logic [7:0]  a_lat;
    logic [7:0]  b_lat;
    logic [7:0]  c_lat;
    logic [7:0]  a_in_lat;
    logic [7:0]  b_in_lat;
    logic        ibf_a;
    logic        ibf_b;
    logic        obf_a;
    logic        obf_b;
    logic        irq_enable_flop_a;
    logic        irq_enable_flop_b;
    logic [7:0]  prev_c;
    ppp_pins_s   pin_out;
    ppp_pins_s   pin_oe;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ppp_state_s;

  localparam ppp_state_s PPP_STATE_RESET = '{ctl: PPP_CTL_RESET, default: '0};

endpackage : ppp_pkg

// ### verilog/ppp_sync2.sv
// two-flop synchroniser for the port pin inputs
`timescale 1ns/1ns
module ppp_sync2 #(
  parameter int WIDTH = 24
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             pclk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else if (pclk_en) begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;

endmodule : ppp_sync2

// ### testbench/ppp_ports_props.sv
// assertion checker for the peripheral ports
`timescale 1ns/1ns
module ppp_ports_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        pclk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  first_port_pins_in,
  input wire logic [7:0]  first_port_pins_out,
  input wire logic [7:0]  first_port_pins_oe,
  input wire logic [7:0]  second_port_pins_in,
  input wire logic [7:0]  second_port_pins_out,
  input wire logic [7:0]  second_port_pins_oe,
  input wire logic [7:0]  third_port_pins_in,
  input wire logic [7:0]  third_port_pins_out,
  input wire logic [7:0]  third_port_pins_oe
);
  logic [7:0] ctl_reg;
  logic       wr_ok;
  logic       mw_basic;
  logic       a_strb;
  assign wr_ok = psel & penable & pready & pwrite & pclk_en & (paddr == 8'h0C);
  assign mw_basic = wr_ok & pwdata[7] & (pwdata[6:5] == 2'h0) & !pwdata[2];
  assign a_strb = (ctl_reg[6:5] == 2'h1) & ctl_reg[4];
  // shadow of the write-only control word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctl_reg <= 8'h1B;
    else if (wr_ok && pwdata[7]) ctl_reg <= pwdata[7:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_reset_idle: assert property ($rose(presetn) |-> {first_port_pins_oe, second_port_pins_oe, third_port_pins_oe} == 24'h0)
    else $error("port driven after reset");
  chk_mode_clear: assert property (mw_basic |=> {first_port_pins_out, second_port_pins_out, third_port_pins_out} == 24'h0)
    else $error("outputs not cleared by mode write");
  chk_dir_a: assert property (mw_basic |=> first_port_pins_oe == {8{!$past(pwdata[4])}})
    else $error("port a direction wrong");
  chk_dir_b: assert property (mw_basic |=> second_port_pins_oe == {8{!$past(pwdata[1])}})
    else $error("port b direction wrong");
  chk_dir_c: assert property (mw_basic |=> third_port_pins_oe == {{4{!$past(pwdata[3])}}, {4{!$past(pwdata[0])}}})
    else $error("port c half direction wrong");
  chk_bit_set: assert property (wr_ok && !pwdata[7] && ctl_reg[6:5] == 2'h0 && ctl_reg[3:0] == 4'h0
    |=> third_port_pins_out[$past(pwdata[3:1])] == $past(pwdata[0])) else $error("port c bit not set");
  chk_ctl_wo: assert property (psel && penable && pready && !pwrite && paddr == 8'h0C |-> prdata == 32'h0)
    else $error("control word read back");
  chk_read_in: assert property (psel && !penable && !pwrite && paddr == 8'h00 && ctl_reg[6:4] == 3'h1
    |=> prdata[7:0] == $past(first_port_pins_in, 3))
    else $error("port a read not pin level");
  chk_full_rise: assert property (a_strb && $fell(third_port_pins_in[4]) |-> ##[1:4] third_port_pins_out[5])
    else $error("buffer full not raised");
  chk_req_full: assert property (a_strb && third_port_pins_out[3] |-> third_port_pins_out[5])
    else $error("request without buffer full");
  cover property (mw_basic);
  cover property (wr_ok && !pwdata[7]);
  cover property (a_strb && third_port_pins_out[3]);
endmodule : ppp_ports_props
bind ppp_ports ppp_ports_props u_props (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .first_port_pins_in(first_port_pins_in), .first_port_pins_out(first_port_pins_out),
  .first_port_pins_oe(first_port_pins_oe), .second_port_pins_in(second_port_pins_in),
  .second_port_pins_out(second_port_pins_out), .second_port_pins_oe(second_port_pins_oe),
  .third_port_pins_in(third_port_pins_in), .third_port_pins_out(third_port_pins_out),
  .third_port_pins_oe(third_port_pins_oe));

// ### testbench/ppp_peripheral.sv
// peripheral model on the port pins
`timescale 1ns/1ns
module ppp_peripheral (
  input  wire logic               pclk,
  input  wire ppp_pkg::ppp_pins_s dut_out,
  input  wire ppp_pkg::ppp_pins_s dut_oe,
  input  wire ppp_pkg::ppp_pins_s ext_val,
  input  wire logic               strobe_n,
  output ppp_pkg::ppp_pins_s      pin_lvl
);
  ppp_pkg::ppp_pins_s data_hold;
  // data held steady while the strobe is low
  always_ff @(posedge pclk) begin
    if (strobe_n) data_hold <= ext_val;
  end
  // wire level: device drive wins, else peripheral
  always_comb begin
    pin_lvl = (dut_out & dut_oe) | (data_hold & ~dut_oe);
    if (!dut_oe.c[4]) pin_lvl.c[4] = strobe_n;
  end
endmodule : ppp_peripheral

// ### testbench/ppp_ports_tb.sv
// self-checking bench for the peripheral ports
`timescale 1ns/1ns
module ppp_ports_tb;
  typedef struct packed { logic [7:0] ctl; logic [23:0] oe; logic [7:0] rd; } ppp_row_s;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, strobe_n, slverr_seen;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd;
  ppp_pkg::ppp_pins_s p_out, p_oe, p_in, ext_val;
  int                 err_count, samples_checked;
  ppp_row_s rows [5] = '{'{8'h80, 24'hFFFFFF, 8'hA5}, '{8'h9B, 24'h000000, 8'h3C},
    '{8'h92, 24'h0000FF, 8'h3C}, '{8'h89, 24'hFFFF00, 8'hA5}, '{8'h83, 24'hFF00F0, 8'hA5}};
  ppp_ports DUT (.pclk(pclk), .presetn(presetn), .pclk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_port_pins_in(p_in.a), .first_port_pins_out(p_out.a), .first_port_pins_oe(p_oe.a),
    .second_port_pins_in(p_in.b), .second_port_pins_out(p_out.b), .second_port_pins_oe(p_oe.b),
    .third_port_pins_in(p_in.c), .third_port_pins_out(p_out.c), .third_port_pins_oe(p_oe.c));
  ppp_peripheral PEER (.pclk(pclk), .dut_out(p_out), .dut_oe(p_oe), .ext_val(ext_val),
    .strobe_n(strobe_n), .pin_lvl(p_in));
  // ----
  // tasks
  // ----
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      err_count++;
      report_and_stop();
    end
    rd = prdata;
    slverr_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wait_c(input int k);
    for (int n = 0; n < 12 && p_out.c[k] !== 1'b1; n++) @(posedge pclk);
    chk("c_high", {31'h0, p_out.c[k]}, 32'h1);
  endtask : wait_c
  task automatic pulse();
    strobe_n <= 1'b0;
    repeat (4) @(posedge pclk);
    strobe_n <= 1'b1;
    @(posedge pclk);
  endtask : pulse
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // ----
  // main sequence
  // ----
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    strobe_n = 1'b1;
    ext_val = '{a: 8'h3C, b: 8'h66, c: 8'h5A};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("oe_rst", {8'h0, p_oe}, 32'h0);
    apb(1'b0, 8'h0C, 8'h00); chk("ctl_rd", rd, 32'h0);
    apb(1'b0, 8'h10, 8'h00); chk("unmapped", {31'h0, slverr_seen}, 32'h1);
    $display("test reset done");
    foreach (rows[i]) begin
      apb(1'b1, 8'h0C, rows[i].ctl);
      chk("oe", {8'h0, p_oe}, {8'h0, rows[i].oe});
      chk("out", {8'h0, p_out}, 32'h0);
      apb(1'b1, 8'h00, 8'hA5);
      apb(1'b1, 8'h04, 8'h5C);
      apb(1'b1, 8'h08, 8'hC3);
      apb(1'b0, 8'h00, 8'h00); chk("rd_a", rd, {24'h0, rows[i].rd});
      apb(1'b0, 8'h04, 8'h00);
      chk("rd_b", rd, {24'h0, (rows[i].ctl[1] ? 8'h66 : 8'h5C)});
      apb(1'b0, 8'h08, 8'h00);
      chk("rd_c", rd, {24'h0, (rows[i].ctl[3] ? 4'h5 : 4'hC), (rows[i].ctl[0] ? 4'hA : 4'h3)});
    end
    $display("test rows done");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("oe_mid_rst", {8'h0, p_oe}, 32'h0);
    chk("out_mid_rst", {8'h0, p_out}, 32'h0);
    repeat (2) @(posedge pclk);
    apb(1'b0, 8'h00, 8'h00);
    chk("rd_mid_rst", rd, 32'h3C);
    $display("test mid reset done");
    apb(1'b1, 8'h0C, 8'h80);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 8'h0C, {4'h0, i[2:0], 1'b1}); chk("c_set", {24'h0, p_out.c}, {24'h0, 8'hFF >> (7 - i)});
    end
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 8'h0C, {4'h7, i[2:0], 1'b0}); chk("c_clr", {24'h0, p_out.c}, {24'h0, 8'hFE << i});
    end
    apb(1'b1, 8'h0C, 8'h0B);
    apb(1'b1, 8'h0C, 8'h80); chk("c_mode", {24'h0, p_out.c}, 32'h0);
    $display("test bits done");
    ext_val.a <= 8'h5A;
    apb(1'b1, 8'h0C, 8'hBB);
    apb(1'b1, 8'h0C, 8'h09);
    pulse(); wait_c(5);
    wait_c(3);
    apb(1'b0, 8'h00, 8'h00); chk("strb_rd", rd, 32'h5A);
    chk("ibf_clr", {24'h0, p_out.c[5], 1'b0, p_out.c[3]}, 32'h0);
    apb(1'b1, 8'h0C, 8'h0C);
    pulse(); wait_c(5);
    repeat (6) @(posedge pclk);
    chk("req_off", {31'h0, p_out.c[3]}, 32'h0);
    apb(1'b0, 8'h00, 8'h00);
    apb(1'b1, 8'h0C, 8'h0D);
    pulse(); wait_c(3);
    apb(1'b1, 8'h0C, 8'hBB);
    chk("strb_mode", {30'h0, p_out.c[5], p_out.c[3]}, 32'h0);
    pulse();
    repeat (6) @(posedge pclk);
    chk("req_mode", {31'h0, p_out.c[3]}, 32'h0);
    apb(1'b1, 8'h0C, 8'hC0);
    chk("bidir_c", {16'h0, p_out.c, p_oe.c}, 32'h80AF);
    apb(1'b1, 8'h00, 8'h3C);
    chk("bidir_wr", {16'h0, p_out.c, p_oe.a}, 32'h0);
    $display("test strobe done");
    report_and_stop();
  end
endmodule : ppp_ports_tb
